/* pkg/usdp_consts.svh */
`ifndef USDP_CONSTS_SVH
`define USDP_CONSTS_SVH
// ----------------------------------------
// Register addresses (byte addresses)
// ----------------------------------------
`define USDP_DATA_ADDR 32'h50001140
`define USDP_CTRL_ADDR 32'h50001200
`define USDP_STAT_ADDR 32'h50001204
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define USDP_CTRL_FIFO_EN 0
`define USDP_CTRL_IR_MODE 1
`define USDP_STAT_DATA_READY 0
`define USDP_STAT_OE 1
`define USDP_STAT_HOLD_EMPTY 5
`define USDP_CTRL_RESET 2'h0
`define USDP_CHAR_RESET 8'h00
// ----------------------------------------
// Buffer depths
// ----------------------------------------
`define USDP_FIFO_DEPTH 16
`define USDP_SKID_DEPTH 2
// ----------------------------------------
// Timing
// ----------------------------------------
`define USDP_CLK_HZ 25000000
`define USDP_BAUD 115200
`define USDP_OVERSAMPLE 16
`define USDP_TICK_CYCLES (`USDP_CLK_HZ / (`USDP_BAUD * `USDP_OVERSAMPLE))
`define USDP_MID_TICK 4'h7
`define USDP_LAST_TICK 4'hf
`define USDP_IR_PULSE_TICKS 4'h3
`endif

/* pkg/usdp_pkg.sv */
// ----------------------------------------
// Types shared by the data port
// ----------------------------------------
package usdp_pkg;
  // Serial framing states, used by both directions
  typedef enum logic [1:0] {st_idle, st_start, st_data, st_stop} usdp_frame_state_type;
endpackage : usdp_pkg

/* src/usdp_fifo.sv */
// ----------------------------------------
// Parameterised first-in first-out buffer
// ----------------------------------------
module usdp_fifo
  import usdp_pkg::*;
#(
  parameter int WIDTH = 8, // Word width
  parameter int DEPTH = 16 // Entries, power of two
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage, not reset
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next; // Write pointer
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next; // Read pointer
  logic [AW:0] count_reg, count_next; // Fill level
  logic push; // Word accepted
  logic pop; // Word delivered

  // Flags and next pointers
  always_comb begin
    in_ready = (count_reg != (AW+1)'(DEPTH)); // Honest full
    out_valid = (count_reg != '0); // Honest empty
    out_data = mem_reg[rd_ptr_reg];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Pointer and level registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // Storage write, data needs no reset
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule : usdp_fifo

/* src/usdp_top.sv */
`include "usdp_consts.svh"
module usdp_top
  import usdp_pkg::*;
(
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [31:0] reg_addr, // Byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic serial_rx, // Serial receive pin
  input wire logic ir_rx, // Infrared receive pin, pulse low
  output logic serial_tx, // Serial transmit pin
  output logic ir_tx_n // Infrared transmit pin, active low
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] ctrl_reg, ctrl_next; // Fifo enable, infrared mode
  logic fifo_en; // Fifo mode selected
  logic ir_mode; // Infrared pins selected
  logic [31:0] rdata_reg, rdata_next; // Read data register
  logic overrun_reg, overrun_next; // Sticky overrun flag
  logic data_wr; // Write to data location
  logic data_rd; // Read of data location
  logic stat_rd; // Read of status location
  logic [3:0] tick_cnt_reg, tick_cnt_next; // Oversample divider
  logic tick_reg, tick_next; // Oversample enable pulse
  logic [2:0] rx_sync_reg, rx_sync_next; // Serial pin synchroniser
  logic [2:0] ir_sync_reg, ir_sync_next; // Infrared pin synchroniser
  logic rx_level_reg, rx_level_next; // Filtered serial level
  logic ir_level_reg, ir_level_next; // Filtered infrared level
  logic ir_low_reg, ir_low_next; // Infrared pulse seen since sample
  logic rx_line; // Receive line after source select
  logic rx_sample; // Receive sample point
  usdp_frame_state_type rx_state_reg, rx_state_next; // Receive framer
  logic [3:0] rx_cnt_reg, rx_cnt_next; // Ticks within bit
  logic [2:0] rx_bit_reg, rx_bit_next; // Data bit index
  logic [7:0] rx_shift_reg, rx_shift_next; // Receive shifter
  logic rx_done_reg, rx_done_next; // Character complete pulse
  logic [7:0] rx_hold_reg, rx_hold_next; // Single receive buffer
  logic rx_hold_valid_reg, rx_hold_valid_next; // Single buffer full
  logic rxf_in_ready; // Receive fifo has room
  logic rxf_out_valid; // Receive fifo not empty
  logic [7:0] rxf_out_data; // Receive fifo head
  logic data_ready; // Data-ready flag
  logic [7:0] rx_head; // Byte presented on read
  logic [7:0] tx_hold_reg, tx_hold_next; // Single transmit holding
  logic tx_hold_full_reg, tx_hold_full_next; // Holding occupied
  logic txf_in_ready; // Transmit fifo has room
  logic txf_out_valid; // Transmit fifo not empty
  logic [7:0] txf_out_data; // Transmit fifo head
  logic txf_out_ready; // Transmit fifo drained
  logic tx_holding_empty; // Transmit holding empty flag
  logic skid_in_valid; // Buffer fill side valid
  logic skid_in_ready; // Buffer fill side ready
  logic [7:0] skid_in_data; // Buffer fill side data
  logic skid_out_valid; // Buffer drain side valid
  logic skid_out_ready; // Buffer drain side ready
  logic [7:0] skid_out_data; // Buffer drain side data
  usdp_frame_state_type tx_state_reg, tx_state_next; // Transmit framer
  logic [3:0] tx_cnt_reg, tx_cnt_next; // Ticks within bit
  logic [2:0] tx_bit_reg, tx_bit_next; // Data bit index
  logic [7:0] tx_shift_reg, tx_shift_next; // Transmit shifter
  logic tx_bit_val; // Current line bit
  logic serial_tx_reg, serial_tx_next; // Serial pin register
  logic ir_tx_n_reg, ir_tx_n_next; // Infrared pin register

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Decode; the data location aliases both directions
  always_comb begin
    fifo_en = ctrl_reg[`USDP_CTRL_FIFO_EN];
    ir_mode = ctrl_reg[`USDP_CTRL_IR_MODE];
    data_wr = reg_wr && (reg_addr == `USDP_DATA_ADDR);
    data_rd = reg_rd && (reg_addr == `USDP_DATA_ADDR);
    stat_rd = reg_rd && (reg_addr == `USDP_STAT_ADDR);
    data_ready = fifo_en ? rxf_out_valid : rx_hold_valid_reg;
    tx_holding_empty = fifo_en ? !txf_out_valid : !tx_hold_full_reg;
    rx_head = fifo_en ? rxf_out_data : rx_hold_reg;
    ctrl_next = ctrl_reg;
    if (reg_wr && (reg_addr == `USDP_CTRL_ADDR)) begin
      ctrl_next = reg_wdata[1:0];
    end
    // Read data stand one cycle only, zero otherwise
    rdata_next = 32'h0;
    if (data_rd) begin
      rdata_next[7:0] = rx_head;
    end else if (reg_rd && (reg_addr == `USDP_CTRL_ADDR)) begin
      rdata_next[1:0] = ctrl_reg;
    end else if (stat_rd) begin
      rdata_next[`USDP_STAT_DATA_READY] = data_ready;
      rdata_next[`USDP_STAT_OE] = overrun_reg;
      rdata_next[`USDP_STAT_HOLD_EMPTY] = tx_holding_empty;
    end
    // Overrun: a new event wins over the status-read clear
    overrun_next = stat_rd ? 1'b0 : overrun_reg;
    if (rx_done_reg && !fifo_en && rx_hold_valid_reg && !data_rd) begin
      overrun_next = 1'b1;
    end
    if (rx_done_reg && fifo_en && !rxf_in_ready) begin
      overrun_next = 1'b1;
    end
  end

  // Register port state
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_reg <= `USDP_CTRL_RESET;
      rdata_reg <= 32'h0;
      overrun_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      overrun_reg <= overrun_next;
    end
  end

  // ----------------------------------------
  // Oversample divider and pin synchronisers
  // ----------------------------------------
  // Change counts once second and third stages agree
  always_comb begin
    tick_next = (tick_cnt_reg == 4'(`USDP_TICK_CYCLES - 1));
    tick_cnt_next = tick_next ? 4'h0 : tick_cnt_reg + 4'h1;
    rx_sync_next = {rx_sync_reg[1:0], serial_rx};
    ir_sync_next = {ir_sync_reg[1:0], ir_rx};
    rx_level_next = (rx_sync_reg[1] == rx_sync_reg[2]) ? rx_sync_reg[2] : rx_level_reg;
    ir_level_next = (ir_sync_reg[1] == ir_sync_reg[2]) ? ir_sync_reg[2] : ir_level_reg;
  end

  // Divider and synchroniser registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tick_cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
      rx_sync_reg <= 3'h7;
      ir_sync_reg <= 3'h7;
      rx_level_reg <= 1'b1;
      ir_level_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
      rx_sync_reg <= rx_sync_next;
      ir_sync_reg <= ir_sync_next;
      rx_level_reg <= rx_level_next;
      ir_level_reg <= ir_level_next;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Infrared zero bits are short low pulses, so a pulse seen
  // anywhere since the last sample point reads as a zero
  always_comb begin
    rx_line = ir_mode ? !(ir_low_reg || !ir_level_reg) : rx_level_reg;
    rx_sample = tick_reg && (((rx_state_reg == st_start) && (rx_cnt_reg == `USDP_MID_TICK)) ||
      (((rx_state_reg == st_data) || (rx_state_reg == st_stop)) && (rx_cnt_reg == `USDP_LAST_TICK)));
    ir_low_next = rx_sample ? 1'b0 : (ir_low_reg || !ir_level_reg);
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_shift_next = rx_shift_reg;
    rx_done_next = 1'b0;
    if (tick_reg) begin
      rx_cnt_next = rx_cnt_reg + 4'h1;
      case (rx_state_reg)
        st_idle: begin
          rx_cnt_next = 4'h0;
          if (!rx_line) begin
            rx_state_next = st_start; // Start edge
          end
        end
        st_start: begin
          if (rx_sample) begin
            rx_cnt_next = 4'h0;
            rx_bit_next = 3'h0;
            rx_state_next = rx_line ? st_idle : st_data; // Glitch returns
          end
        end
        st_data: begin
          if (rx_sample) begin
            rx_shift_next = {rx_line, rx_shift_reg[7:1]}; // Least bit first
            rx_bit_next = rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_next = st_stop;
            end
          end
        end
        st_stop: begin
          if (rx_sample) begin
            rx_done_next = 1'b1; // Stop bit level not checked
            rx_state_next = st_idle;
          end
        end
        default: rx_state_next = st_idle;
      endcase
    end
    // Single buffer: arrival overwrites, a read empties it
    rx_hold_next = rx_hold_reg;
    rx_hold_valid_next = rx_hold_valid_reg;
    if (!fifo_en && rx_done_reg) begin
      rx_hold_next = rx_shift_reg;
      rx_hold_valid_next = 1'b1;
    end else if (!fifo_en && data_rd) begin
      rx_hold_valid_next = 1'b0;
    end
  end

  // Receiver registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ir_low_reg <= 1'b0;
      rx_state_reg <= st_idle;
      rx_cnt_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= `USDP_CHAR_RESET;
      rx_done_reg <= 1'b0;
      rx_hold_reg <= `USDP_CHAR_RESET;
      rx_hold_valid_reg <= 1'b0;
    end else begin
      ir_low_reg <= ir_low_next;
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
      rx_done_reg <= rx_done_next;
      rx_hold_reg <= rx_hold_next;
      rx_hold_valid_reg <= rx_hold_valid_next;
    end
  end

  // Receive fifo: a full fifo refuses, so the new byte is lost
  usdp_fifo #(.WIDTH(8), .DEPTH(`USDP_FIFO_DEPTH)) u_rx_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_data(rx_shift_reg),
    .in_valid(fifo_en && rx_done_reg),
    .in_ready(rxf_in_ready),
    .out_data(rxf_out_data),
    .out_valid(rxf_out_valid),
    .out_ready(fifo_en && data_rd)
  );

  // ----------------------------------------
  // Transmit holding and fifo
  // ----------------------------------------
  // Transmit fifo: writes beyond sixteen are dropped
  usdp_fifo #(.WIDTH(8), .DEPTH(`USDP_FIFO_DEPTH)) u_tx_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_data(reg_wdata[7:0]),
    .in_valid(fifo_en && data_wr),
    .in_ready(txf_in_ready),
    .out_data(txf_out_data),
    .out_valid(txf_out_valid),
    .out_ready(txf_out_ready)
  );

  // Holding register; a new write wins over the drain
  always_comb begin
    skid_in_data = fifo_en ? txf_out_data : tx_hold_reg;
    skid_in_valid = fifo_en ? txf_out_valid : tx_hold_full_reg;
    txf_out_ready = fifo_en && skid_in_ready;
    tx_hold_next = tx_hold_reg;
    tx_hold_full_next = tx_hold_full_reg;
    if (!fifo_en && data_wr) begin
      tx_hold_next = reg_wdata[7:0];
      tx_hold_full_next = 1'b1;
    end else if (!fifo_en && skid_in_ready) begin
      tx_hold_full_next = 1'b0;
    end
  end

  // Holding registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_hold_reg <= `USDP_CHAR_RESET;
      tx_hold_full_reg <= 1'b0;
    end else begin
      tx_hold_reg <= tx_hold_next;
      tx_hold_full_reg <= tx_hold_full_next;
    end
  end

  // Two-entry buffer; a busy framer stalls it and then the source
  usdp_fifo #(.WIDTH(8), .DEPTH(`USDP_SKID_DEPTH)) u_tx_skid (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_data(skid_in_data),
    .in_valid(skid_in_valid),
    .in_ready(skid_in_ready),
    .out_data(skid_out_data),
    .out_valid(skid_out_valid),
    .out_ready(skid_out_ready)
  );

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  // Framer; infrared zero bits become 3/16-bit low pulses
  always_comb begin
    // Start only on a tick, so the start bit gets sixteen whole ticks
    // and its infrared pulse the same three as every data bit
    skid_out_ready = (tx_state_reg == st_idle) && tick_reg;
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_shift_next = tx_shift_reg;
    case (tx_state_reg)
      st_idle: begin
        if (skid_out_valid && skid_out_ready) begin
          tx_shift_next = skid_out_data;
          tx_cnt_next = 4'h0;
          tx_bit_next = 3'h0;
          tx_state_next = st_start;
        end
      end
      st_start, st_data, st_stop: begin
        if (tick_reg) begin
          tx_cnt_next = tx_cnt_reg + 4'h1;
          if (tx_cnt_reg == `USDP_LAST_TICK) begin
            if (tx_state_reg == st_start) begin
              tx_state_next = st_data;
            end else if (tx_state_reg == st_stop) begin
              tx_state_next = st_idle;
            end else begin
              tx_shift_next = {1'b1, tx_shift_reg[7:1]};
              tx_bit_next = tx_bit_reg + 3'h1;
              if (tx_bit_reg == 3'h7) begin
                tx_state_next = st_stop;
              end
            end
          end
        end
      end
      default: tx_state_next = st_idle;
    endcase
    tx_bit_val = (tx_state_reg == st_start) ? 1'b0 :
      ((tx_state_reg == st_data) ? tx_shift_reg[0] : 1'b1);
    serial_tx_next = ir_mode ? 1'b1 : tx_bit_val;
    ir_tx_n_next = !(ir_mode && !tx_bit_val && (tx_cnt_reg < `USDP_IR_PULSE_TICKS));
  end

  // Transmitter registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_state_reg <= st_idle;
      tx_cnt_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_shift_reg <= `USDP_CHAR_RESET;
      serial_tx_reg <= 1'b1;
      ir_tx_n_reg <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
      serial_tx_reg <= serial_tx_next;
      ir_tx_n_reg <= ir_tx_n_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign serial_tx = serial_tx_reg;
  assign ir_tx_n = ir_tx_n_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_data_upper_zero: assert property (data_rd |=> reg_rdata[31:8] == 24'h0)
    else $error("data read upper bits not zero");
  a_fifo_head_read: assert property (data_rd && fifo_en |=> reg_rdata[7:0] == $past(rxf_out_data))
    else $error("fifo read did not return head");
  a_hold_overwrite: assert property (!fifo_en && data_wr |=> tx_hold_reg == $past(reg_wdata[7:0]))
    else $error("holding not replaced by write");
  a_hold_empty_clears: assert property (!fifo_en && data_wr ##1 !fifo_en |-> !tx_holding_empty)
    else $error("holding-empty still set after write");
  a_rx_overwrite: assert property (!fifo_en && rx_done_reg && rx_hold_valid_reg && !data_rd
    |=> overrun_reg && rx_hold_reg == $past(rx_shift_reg))
    else $error("overwrite without overrun");
  a_rx_full_drop: assert property (fifo_en && rx_done_reg && !rxf_in_ready && !data_rd
    |=> overrun_reg && !rxf_in_ready)
    else $error("full fifo accepted byte or no overrun");
  a_read_empties: assert property (!fifo_en && data_rd && !rx_done_reg |=> !rx_hold_valid_reg)
    else $error("read did not empty buffer");
  a_tx_full_drop: assert property (fifo_en && data_wr && !txf_in_ready && !txf_out_ready
    |=> !txf_in_ready)
    else $error("write to full fifo changed level");
  a_serial_start_low: assert property (tx_state_reg == st_start && !ir_mode |=> !serial_tx)
    else $error("start bit not low on serial pin");
  a_ir_serial_idle: assert property (ir_mode |=> serial_tx)
    else $error("serial pin active in infrared mode");
  a_rx_serial_start: assert property (!ir_mode && rx_state_reg == st_idle && tick_reg && !rx_level_reg
    |=> rx_state_reg == st_start)
    else $error("serial start edge missed");

  c_rx_overrun: cover property (rx_done_reg && fifo_en && !rxf_in_ready);
  c_tx_fifo_full: cover property (fifo_en && !txf_in_ready);
  c_tx_frame: cover property (tx_state_reg == st_stop ##1 tx_state_reg == st_idle);
  c_ir_pulse: cover property (ir_mode && !ir_tx_n);
endmodule : usdp_top

/* testbench/usdp_remote.sv */
// ----------------------------------------
// Remote serial transceiver and infrared transmitter
// ----------------------------------------
module usdp_remote (
  input wire logic ref_clk,
  input wire logic serial_tx,
  input wire logic ir_tx_n,
  output logic serial_rx,
  output logic ir_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT_CYC = 208; // 16 ticks of 13 clocks
  logic [7:0] got[$]; // Bytes seen on the serial pin
  logic [7:0] cap; // Capture shifter
  // Both receive lines idle high, like a pulled-up line
  initial begin
    serial_rx = 1'b1;
    ir_rx = 1'b1;
  end
  // One 8N1 frame, LSB first; an infrared 0 is a short low pulse
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < BIT_CYC; c++) begin
        @(posedge ref_clk);
        if (ir) begin
          ir_rx <= fr[i] | (c >= 39);
        end else begin
          serial_rx <= fr[i];
        end
      end
    end
  endtask : send
  // Samples mid-bit; the infrared output is judged by the bench
  always begin
    @(negedge serial_tx);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      cap[i] = serial_tx;
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    got.push_back(cap);
  end
endmodule : usdp_remote

/* testbench/usdp_top_tb_top.sv */
`include "usdp_consts.svh"
module usdp_top_tb_top;
  import usdp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic serial_rx, ir_rx, serial_tx, ir_tx_n;
  int err_total = 0;
  int n_compared = 0;
  localparam logic [31:0] ALL = 32'hffffffff;
  usdp_remote remote (.ref_clk(ref_clk), .serial_tx(serial_tx), .ir_tx_n(ir_tx_n),
    .serial_rx(serial_rx), .ir_rx(ir_rx));
  usdp_top uut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx(serial_rx),
    .ir_rx(ir_rx), .serial_tx(serial_tx), .ir_tx_n(ir_tx_n));
  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stands one cycle only, so it is sampled just after that edge
  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask : rdc
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(`USDP_DATA_ADDR, ALL, 32'h0);
    rdc(`USDP_CTRL_ADDR, ALL, 32'h0);
    rdc(`USDP_STAT_ADDR, ALL, 32'h20);
    rdc(32'h50001300, ALL, 32'h0);
  endtask : t_reset
  task automatic t_rx_serial();
    remote.send(8'ha5, 1'b0);
    repeat (20) @(posedge ref_clk);
    rdc(`USDP_STAT_ADDR, 32'h1, 32'h1);
    rdc(`USDP_DATA_ADDR, ALL, 32'ha5);
    rdc(`USDP_STAT_ADDR, 32'h1, 32'h0);
  endtask : t_rx_serial
  // Unread byte is overwritten and overrun is flagged
  task automatic t_overrun();
    remote.send(8'h3c, 1'b0);
    remote.send(8'hc3, 1'b0);
    repeat (20) @(posedge ref_clk);
    rdc(`USDP_DATA_ADDR, ALL, 32'hc3);
    rdc(`USDP_STAT_ADDR, 32'h3, 32'h2);
  endtask : t_overrun
  task automatic t_ir();
    int lows;
    int sl;
    lows = 0;
    sl = 0;
    wr(`USDP_CTRL_ADDR, 32'h2);
    remote.send(8'h5a, 1'b1);
    repeat (20) @(posedge ref_clk);
    rdc(`USDP_DATA_ADDR, ALL, 32'h5a);
    wr(`USDP_DATA_ADDR, 32'h0);
    // Start plus eight zero bits, each pulsed for 3 ticks of 13 clocks
    repeat (2300) begin
      @(posedge ref_clk);
      lows += (ir_tx_n === 1'b0);
      sl += (serial_tx !== 1'b1);
    end
    chk(lows, 351);
    chk(sl, 0);
  endtask : t_ir
  // Framer busy and buffer full, so the last write replaces the pending one
  task automatic t_tx_overwrite();
    logic [7:0] exp[4];
    exp = '{8'h11, 8'h22, 8'h33, 8'h55};
    wr(`USDP_CTRL_ADDR, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`USDP_DATA_ADDR, {24'h00ab00, exp[i]});
      repeat (6) @(posedge ref_clk);
    end
    wr(`USDP_DATA_ADDR, 32'h44);
    wr(`USDP_DATA_ADDR, 32'h55);
    rdc(`USDP_STAT_ADDR, 32'h20, 32'h0);
    repeat (8800) @(posedge ref_clk);
    chk(remote.got.size(), 4);
    for (int i = 0; i < remote.got.size() && i < 4; i++) begin
      chk(remote.got[i], exp[i]);
    end
  endtask : t_tx_overwrite
  // Twenty writes meet framer, buffer and queue (nineteen places), then
  // seventeen arrivals into a sixteen-entry receive queue while those go out
  task automatic t_rx_fifo();
    wr(`USDP_CTRL_ADDR, 32'h1);
    for (int i = 0; i < 20; i++) begin
      wr(`USDP_DATA_ADDR, {24'h0, 8'h60 + i[7:0]});
    end
    rdc(`USDP_STAT_ADDR, 32'h20, 32'h0);
    for (int i = 0; i < 17; i++) begin
      remote.send(8'h40 + i[7:0], 1'b0);
    end
    repeat (20) @(posedge ref_clk);
    rdc(`USDP_STAT_ADDR, 32'h3, 32'h3);
    for (int i = 0; i < 16; i++) begin
      rdc(`USDP_DATA_ADDR, ALL, {24'h0, 8'h40 + i[7:0]});
    end
    rdc(`USDP_STAT_ADDR, 32'h1, 32'h0);
    // The transmit queue outlasts the receive side; the twentieth byte is lost
    repeat (5000) @(posedge ref_clk);
    chk(remote.got.size(), 23);
    for (int i = 4; i < remote.got.size() && i < 23; i++) begin
      chk(remote.got[i], 8'h5c + i[7:0]);
    end
  endtask : t_rx_fifo
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // Tests take about 60000 cycles; this leaves ample margin
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    results();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    t_reset();
    t_rx_serial();
    t_overrun();
    t_ir();
    t_tx_overwrite();
    t_rx_fifo();
    results();
  end
endmodule : usdp_top_tb_top
